// >>> hw/mwd_pkg.sv
/*
 * Shared constants, field layout and types of the microword register and its decode.
 * Assumes one 40 MHz clock, a synchronous active-high reset and classic Wishbone access.
 */
// Overview of operation
// (RQ1) A 60-bit register holds the microword that runs in the current microcycle.
// (RQ2) The register is loaded on the first run phase from the control store word at the current address.
// (RQ3) The field operations are carried out on the second, third and fourth run phases of that microcycle.
// (RQ4) The four run phases are gated copies of four free phases and toggle only while the run bit is set.
// (RQ5) Bits 00-11 form the jump field and its bits 00-03 drive sequencer direct inputs D11-D8.
// (RQ6) A jump multiplexer feeds sequencer inputs D7-D0 from jump bits 04-11 or bus bits D16-D23.
// (RQ7) Bit 12 is the parity bit and even parity over the checked bits raises the parity error signal.
// (RQ8) Parity covers bits 00-58, not bit 59, and an error sets error and interrupt status and halts the processor.
// (RQ9) Bit 13 enables the ALU Y outputs onto the internal bus, which float otherwise.
// (RQ10) Bits 14-23 form a 10-bit constant field for ALU constants, storage addresses and bus qualifiers.
// (RQ11) Bits 24-26 pick the R,S operands: A,Q; A,B; 0,Q; 0,B; 0,A; D,A; D,Q; D,0.
// (RQ12) Operand A is the RAM word at the A port address and operand B the word at the B port address.
// (RQ13) The function field picks R+S, S-R, R-S, R or S, R and S, not-R and S, R xor S, R xnor S.
// (RQ14) Destinations 0-3: Y gets the ALU result except code 2 (RAM A), Q loads on 0, RAM B loads on 2 and 3.
// (RQ15) Destinations 4-7 write the result halved (4,5) or doubled (6,7) into RAM B, Q shifted on 4 and 6.
// (RQ16) D is built from the constant field and bus bits, Q is the Q register and zero is all zeros.
package mwd_pkg;

    localparam int MW_W   = 60;
    localparam int DW     = 36;
    localparam int CSA_W  = 12;
    localparam int RAM_N  = 16;
    localparam int RA_W   = 4;

    // Microword bit 00 is the most significant bit, index 59
    localparam int MW_JMP_HI  = 59;
    localparam int MW_JMP_MID = 56;
    localparam int MW_JMP_LO  = 48;
    localparam int MW_PAR     = 47;
    localparam int MW_OE      = 46;
    localparam int MW_CST_HI  = 45;
    localparam int MW_CST_LO  = 36;
    localparam int MW_SRC_LO  = 33;
    localparam int MW_FN_LO   = 30;
    localparam int MW_DST_LO  = 27;
    localparam int MW_PA_LO   = 21;
    localparam int MW_PB_LO   = 17;
    localparam int MW_MARK    = 0;

    // Internal bus bit 00 is index 35
    localparam int BUS_JMP_LO = 12;
    localparam int BUS_D_HI   = 25;
    localparam int BUS_D_LO   = 10;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_START  = 8'h08;
    localparam logic [7:0] OFS_MWLO   = 8'h0C;
    localparam logic [7:0] OFS_MWHI   = 8'h10;
    localparam logic [7:0] OFS_QREG   = 8'h14;
    localparam logic [7:0] OFS_RAMSEL = 8'h18;
    localparam logic [7:0] OFS_RAMDAT = 8'h1C;
    localparam logic [7:0] OFS_CSADDR = 8'h20;

    localparam int CTRL_RUN  = 0;
    localparam int CTRL_JSEL = 1;
    localparam int CTRL_FERR = 2;
    localparam int STAT_PERR = 0;
    localparam int STAT_IRQ  = 1;
    localparam int STAT_RUN  = 2;

    localparam logic [CSA_W-1:0] START_RST = 12'h000;
    localparam logic [MW_W-1:0]  MW_RST    = 60'h000000000000000;

    typedef enum logic [2:0] {
        SRC_AQ, SRC_AB, SRC_ZQ, SRC_ZB, SRC_ZA, SRC_DA, SRC_DQ, SRC_DZ
    } mwd_src_t;

    typedef enum logic [2:0] {
        FN_ADD, FN_SUBR, FN_SUBS, FN_OR, FN_AND, FN_NOTRS, FN_XOR, FN_XNOR
    } mwd_fn_t;

    typedef enum logic [2:0] {
        DST_QREG, DST_NOP, DST_RAMA, DST_RAMF, DST_RAMQD, DST_RAMD, DST_RAMQU, DST_RAMU
    } mwd_dst_t;

    typedef struct packed {
        logic [11:0]     jump_field;
        logic            microword_parity_bit;
        logic            alu_output_enable_bit;
        logic [9:0]      constant_field;
        mwd_src_t        alu_source_select;
        mwd_fn_t         alu_function_select;
        mwd_dst_t        alu_destination_select;
        logic [1:0]      cond_mode_bits;
        logic [RA_W-1:0] ram_a_port_address;
        logic [RA_W-1:0] ram_b_port_address;
        logic [15:0]     upper_ctl_bits;
        logic            microword_marker_bit;
    } mwd_fields_t;

    typedef struct packed {
        mwd_src_t        src;
        mwd_fn_t         fn;
        mwd_dst_t        dst;
        logic [RA_W-1:0] a_addr;
        logic [RA_W-1:0] b_addr;
        logic [DW-1:0]   d_op;
    } mwd_alu_ctl_t;

endpackage : mwd_pkg

// >>> hw/mwd_phase_gen.sv
/*
 * Four-phase microcycle generator with run gating.
 * Assumes the run request comes from a register in the same clock domain.
 */
`timescale 1ns/1ps
module mwd_phase_gen (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       run_req,
    output logic [3:0]      gated_phase,
    output logic            processor_running
);
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic       run_ff;
    logic       nxt_run;
    logic [3:0] gated_ff;
    logic [3:0] nxt_gated;

    always_comb begin
        nxt_phase = phase_ff + 2'h1;
        // Run only starts at a microcycle boundary; dropping run_req stops it at once and cuts the cycle short
        nxt_run = (phase_ff == 2'h3) ? run_req : run_ff;
        // (RQ4) gate free phases
        nxt_gated = nxt_run ? (4'h1 << nxt_phase) : 4'h0;
        if (!run_req) begin
            nxt_run   = 1'b0;
            nxt_gated = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_ff <= 2'h3;
            run_ff   <= 1'b0;
            gated_ff <= 4'h0;
        end else begin
            phase_ff <= nxt_phase;
            run_ff   <= nxt_run;
            gated_ff <= nxt_gated;
        end
    end

    assign gated_phase       = gated_ff;
    assign processor_running = run_ff;
endmodule : mwd_phase_gen

// >>> hw/mwd_alu_slice.sv
/*
 * Bit-slice style ALU with 16-word two-port RAM and Q register.
 * Assumes operands and selects stay stable from the compute phase to the commit phase.
 */
`timescale 1ns/1ps
module mwd_alu_slice (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire mwd_pkg::mwd_alu_ctl_t    ctl,
    input  wire logic                     commit,
    input  wire logic [mwd_pkg::RA_W-1:0] peek_addr,
    output logic [mwd_pkg::DW-1:0]        y,
    output logic [mwd_pkg::DW-1:0]        q_value,
    output logic [mwd_pkg::DW-1:0]        peek_data
);
    logic [mwd_pkg::DW-1:0] ram_ff [mwd_pkg::RAM_N];
    logic [mwd_pkg::DW-1:0] nxt_ram [mwd_pkg::RAM_N];
    logic [mwd_pkg::DW-1:0] q_ff;
    logic [mwd_pkg::DW-1:0] nxt_q;
    logic [mwd_pkg::DW-1:0] a_w;
    logic [mwd_pkg::DW-1:0] b_w;
    logic [mwd_pkg::DW-1:0] r_op;
    logic [mwd_pkg::DW-1:0] s_op;
    logic [mwd_pkg::DW-1:0] f_res;
    logic [mwd_pkg::DW-1:0] b_in;

    always_comb begin
        // (RQ12) RAM port operands
        a_w = ram_ff[ctl.a_addr];
        b_w = ram_ff[ctl.b_addr];
        // (RQ11) source select, (RQ16) zero and Q
        r_op = '0;
        s_op = '0;
        case (ctl.src)
            mwd_pkg::SRC_AQ: begin r_op = a_w; s_op = q_ff; end
            mwd_pkg::SRC_AB: begin r_op = a_w; s_op = b_w; end
            mwd_pkg::SRC_ZQ: s_op = q_ff;
            mwd_pkg::SRC_ZB: s_op = b_w;
            mwd_pkg::SRC_ZA: s_op = a_w;
            mwd_pkg::SRC_DA: begin r_op = ctl.d_op; s_op = a_w; end
            mwd_pkg::SRC_DQ: begin r_op = ctl.d_op; s_op = q_ff; end
            mwd_pkg::SRC_DZ: r_op = ctl.d_op;
            default: r_op = '0;
        endcase
        // (RQ13) function select
        case (ctl.fn)
            mwd_pkg::FN_ADD:   f_res = r_op + s_op;
            mwd_pkg::FN_SUBR:  f_res = s_op - r_op;
            mwd_pkg::FN_SUBS:  f_res = r_op - s_op;
            mwd_pkg::FN_OR:    f_res = r_op | s_op;
            mwd_pkg::FN_AND:   f_res = r_op & s_op;
            mwd_pkg::FN_NOTRS: f_res = ~r_op & s_op;
            mwd_pkg::FN_XOR:   f_res = r_op ^ s_op;
            mwd_pkg::FN_XNOR:  f_res = ~(r_op ^ s_op);
            default:           f_res = '0;
        endcase
        // (RQ14) Y and destinations 0-3
        y     = (ctl.dst == mwd_pkg::DST_RAMA) ? a_w : f_res;
        nxt_q = q_ff;
        b_in  = f_res;
        case (ctl.dst)
            mwd_pkg::DST_QREG:  nxt_q = f_res;
            // (RQ15) shifted destinations, zero shifted in
            mwd_pkg::DST_RAMQD: begin b_in = f_res >> 1; nxt_q = q_ff >> 1; end
            mwd_pkg::DST_RAMD:  b_in = f_res >> 1;
            mwd_pkg::DST_RAMQU: begin b_in = f_res << 1; nxt_q = q_ff << 1; end
            mwd_pkg::DST_RAMU:  b_in = f_res << 1;
            default:            b_in = f_res;
        endcase
        for (int i = 0; i < mwd_pkg::RAM_N; i++) begin
            nxt_ram[i] = ram_ff[i];
        end
        if (ctl.dst != mwd_pkg::DST_QREG && ctl.dst != mwd_pkg::DST_NOP) begin
            nxt_ram[ctl.b_addr] = b_in;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q_ff <= '0;
            for (int i = 0; i < mwd_pkg::RAM_N; i++) begin
                ram_ff[i] <= '0;
            end
        end else if (commit) begin
            q_ff <= nxt_q;
            for (int i = 0; i < mwd_pkg::RAM_N; i++) begin
                ram_ff[i] <= nxt_ram[i];
            end
        end
    end

    assign q_value   = q_ff;
    assign peek_data = ram_ff[peek_addr];
endmodule : mwd_alu_slice

// >>> hw/mwd_top.sv
/*
 * Microword register with leading-field decode, parity check and run control.
 * Assumes an external control store answering within one clock, an external
 * microsequencer supplying the next address, and a classic Wishbone master.
 */
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module mwd_top (
    input  wire logic                      REF_CLK,
    input  wire logic                      SRST,
    input  wire logic                      WB_CYC_I,
    input  wire logic                      WB_STB_I,
    input  wire logic                      WB_WE_I,
    input  wire logic [7:0]                WB_ADR_I,
    input  wire logic [3:0]                WB_SEL_I,
    input  wire logic [31:0]               WB_DAT_I,
    output logic [31:0]                    WB_DAT_O,
    output logic                           WB_ACK_O,
    input  wire logic [mwd_pkg::MW_W-1:0]  CS_DATA,
    output logic [mwd_pkg::CSA_W-1:0]      CS_ADDR,
    input  wire logic [mwd_pkg::CSA_W-1:0] NEXT_ADDR,
    output logic [mwd_pkg::CSA_W-1:0]      SEQ_D,
    input  wire logic [mwd_pkg::DW-1:0]    IBUS_IN,
    output logic [mwd_pkg::DW-1:0]         ALU_Y_OUT,
    output logic                           ALU_Y_OE_N,
    output logic [9:0]                     CONSTANT_FIELD,
    output logic                           CONTROL_STORE_PARITY_ERROR,
    output logic [3:0]                     GATED_PHASE,
    output logic                           PROCESSOR_RUNNING
);
    logic                       run_control_bit_ff;
    logic                       nxt_run_control_bit;
    logic                       jsel_ff;
    logic                       nxt_jsel;
    logic                       perr_ff;
    logic                       nxt_perr;
    logic                       irq_ff;
    logic                       nxt_irq;
    logic [mwd_pkg::CSA_W-1:0]  start_ff;
    logic [mwd_pkg::CSA_W-1:0]  nxt_start;
    logic [mwd_pkg::RA_W-1:0]   ramsel_ff;
    logic [mwd_pkg::RA_W-1:0]   nxt_ramsel;
    logic [31:0]                dat_ff;
    logic [31:0]                nxt_dat;
    logic                       ack_ff;
    logic                       nxt_ack;

    logic [mwd_pkg::MW_W-1:0]   mw_ff;
    logic [mwd_pkg::MW_W-1:0]   nxt_mw;
    logic [mwd_pkg::CSA_W-1:0]  csa_ff;
    logic [mwd_pkg::CSA_W-1:0]  nxt_csa;
    logic [mwd_pkg::CSA_W-1:0]  seqd_ff;
    logic [mwd_pkg::CSA_W-1:0]  nxt_seqd;
    logic [mwd_pkg::DW-1:0]     y_ff;
    logic [mwd_pkg::DW-1:0]     nxt_y;
    logic                       oe_n_ff;
    logic                       nxt_oe_n;
    logic [9:0]                 cst_ff;
    logic [9:0]                 nxt_cst;
    logic                       pe_ff;
    logic                       nxt_pe;
    logic                       started_ff;
    logic                       nxt_started;

    logic [3:0]                 gated_phase;
    logic                       running;
    logic                       wb_req;
    logic                       wb_wr;
    logic                       parity_bad;
    logic                       halt_now;
    mwd_pkg::mwd_fields_t       fld;
    mwd_pkg::mwd_alu_ctl_t      alu_ctl;
    logic [mwd_pkg::DW-1:0]     alu_y;
    logic [mwd_pkg::DW-1:0]     q_value;
    logic [mwd_pkg::DW-1:0]     peek_data;

    // Field decode used for the live word only; readback returns the raw word
    function automatic mwd_pkg::mwd_fields_t split_mw(input logic [mwd_pkg::MW_W-1:0] w);
        split_mw = mwd_pkg::mwd_fields_t'(w);
    endfunction : split_mw

    // Odd parity over bits 00-58; the marker bit is left out
    function automatic logic mw_parity_even(input logic [mwd_pkg::MW_W-1:0] w);
        mw_parity_even = ~(^w[mwd_pkg::MW_W-1:mwd_pkg::MW_MARK+1]);
    endfunction : mw_parity_even

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        byte_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                byte_merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction : byte_merge

    mwd_phase_gen u_phase (
        .clk               (REF_CLK),
        .srst              (SRST),
        .run_req           (run_control_bit_ff),
        .gated_phase       (gated_phase),
        .processor_running (running)
    );

    assign fld = split_mw(mw_ff);
    // (RQ16) D operand from constant field and bus bits 10-25
    assign alu_ctl = '{src: fld.alu_source_select, fn: fld.alu_function_select,
                       dst: fld.alu_destination_select, a_addr: fld.ram_a_port_address,
                       b_addr: fld.ram_b_port_address,
                       d_op: {fld.constant_field, IBUS_IN[mwd_pkg::BUS_D_HI:mwd_pkg::BUS_D_LO],
                              fld.constant_field}};

    mwd_alu_slice u_alu (
        .clk       (REF_CLK),
        .srst      (SRST),
        .ctl       (alu_ctl),
        // (RQ3) results commit on phase four
        .commit    (gated_phase[3] && !pe_ff),
        .peek_addr (ramsel_ff),
        .y         (alu_y),
        .q_value   (q_value),
        .peek_data (peek_data)
    );

    assign parity_bad = mw_parity_even(mw_ff);
    // (RQ7) parity checked on phase two
    assign halt_now   = gated_phase[1] && parity_bad;

    // Microword path
    always_comb begin
        nxt_mw      = mw_ff;
        nxt_csa     = csa_ff;
        nxt_seqd    = seqd_ff;
        nxt_y       = y_ff;
        nxt_oe_n    = oe_n_ff;
        nxt_cst     = cst_ff;
        nxt_pe      = pe_ff;
        nxt_started = started_ff;
        if (!running && !run_control_bit_ff) begin
            // Idle: next start comes from the start address register
            nxt_csa     = start_ff;
            nxt_started = 1'b0;
            nxt_oe_n    = 1'b1;
            nxt_pe      = 1'b0;
        end
        if (gated_phase[0]) begin
            // (RQ1) (RQ2) load word on phase one
            nxt_mw      = CS_DATA;
            nxt_started = 1'b1;
            nxt_pe      = 1'b0;
        end
        if (gated_phase[1]) begin
            nxt_pe  = parity_bad;
            // (RQ10) constant field out
            nxt_cst = fld.constant_field;
            // (RQ5) (RQ6) jump field and jump mux
            nxt_seqd = {fld.jump_field[11:8],
                        jsel_ff ? IBUS_IN[mwd_pkg::BUS_JMP_LO+7:mwd_pkg::BUS_JMP_LO]
                                : fld.jump_field[7:0]};
        end
        if (gated_phase[2]) begin
            nxt_y    = alu_y;
            // (RQ9) Y drives the bus only when enabled
            nxt_oe_n = !fld.alu_output_enable_bit || pe_ff;
        end
        if (gated_phase[3]) begin
            nxt_oe_n = 1'b1;
            nxt_csa  = pe_ff ? csa_ff : NEXT_ADDR;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            mw_ff      <= mwd_pkg::MW_RST;
            csa_ff     <= mwd_pkg::START_RST;
            seqd_ff    <= '0;
            y_ff       <= '0;
            oe_n_ff    <= 1'b1;
            cst_ff     <= '0;
            pe_ff      <= 1'b0;
            started_ff <= 1'b0;
        end else begin
            mw_ff      <= nxt_mw;
            csa_ff     <= nxt_csa;
            seqd_ff    <= nxt_seqd;
            y_ff       <= nxt_y;
            oe_n_ff    <= nxt_oe_n;
            cst_ff     <= nxt_cst;
            pe_ff      <= nxt_pe;
            started_ff <= nxt_started;
        end
    end

    assign wb_req = WB_CYC_I && WB_STB_I && !ack_ff;
    assign wb_wr  = wb_req && WB_WE_I;

    // Register file and bus slave
    always_comb begin
        nxt_run_control_bit = run_control_bit_ff;
        nxt_jsel            = jsel_ff;
        nxt_perr            = perr_ff;
        nxt_irq             = irq_ff;
        nxt_start           = start_ff;
        nxt_ramsel          = ramsel_ff;
        nxt_ack             = wb_req;
        nxt_dat             = dat_ff;
        if (wb_wr && WB_SEL_I[0]) begin
            case (WB_ADR_I)
                mwd_pkg::OFS_CTRL: begin
                    nxt_run_control_bit = WB_DAT_I[mwd_pkg::CTRL_RUN];
                    nxt_jsel            = WB_DAT_I[mwd_pkg::CTRL_JSEL];
                    // Forced error acts as a breakpoint halt
                    if (WB_DAT_I[mwd_pkg::CTRL_FERR]) begin
                        nxt_perr            = 1'b1;
                        nxt_run_control_bit = 1'b0;
                    end
                end
                mwd_pkg::OFS_STAT: begin
                    if (WB_DAT_I[mwd_pkg::STAT_PERR]) begin
                        nxt_perr = 1'b0;
                    end
                    if (WB_DAT_I[mwd_pkg::STAT_IRQ]) begin
                        nxt_irq = 1'b0;
                    end
                end
                mwd_pkg::OFS_RAMSEL: nxt_ramsel = WB_DAT_I[mwd_pkg::RA_W-1:0];
                default: nxt_ramsel = ramsel_ff;
            endcase
        end
        if (wb_wr && WB_ADR_I == mwd_pkg::OFS_START) begin
            nxt_start = mwd_pkg::CSA_W'(byte_merge(32'(start_ff), WB_DAT_I, WB_SEL_I));
        end
        // (RQ8) error sets status and halts; set wins over clear
        if (halt_now) begin
            nxt_perr            = 1'b1;
            nxt_irq             = 1'b1;
            nxt_run_control_bit = 1'b0;
        end
        if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
                mwd_pkg::OFS_CTRL:   nxt_dat = {30'h00000000, jsel_ff, run_control_bit_ff};
                mwd_pkg::OFS_STAT:   nxt_dat = {29'h00000000, running, irq_ff, perr_ff};
                mwd_pkg::OFS_START:  nxt_dat = {20'h00000, start_ff};
                mwd_pkg::OFS_MWLO:   nxt_dat = mw_ff[31:0];
                mwd_pkg::OFS_MWHI:   nxt_dat = {4'h0, mw_ff[mwd_pkg::MW_W-1:32]};
                mwd_pkg::OFS_QREG:   nxt_dat = q_value[31:0];
                mwd_pkg::OFS_RAMSEL: nxt_dat = {28'h0000000, ramsel_ff};
                mwd_pkg::OFS_RAMDAT: nxt_dat = peek_data[31:0];
                mwd_pkg::OFS_CSADDR: nxt_dat = {20'h00000, csa_ff};
                default:             nxt_dat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            run_control_bit_ff <= 1'b0;
            jsel_ff            <= 1'b0;
            perr_ff            <= 1'b0;
            irq_ff             <= 1'b0;
            start_ff           <= mwd_pkg::START_RST;
            ramsel_ff          <= '0;
            ack_ff             <= 1'b0;
            dat_ff             <= 32'h00000000;
        end else begin
            run_control_bit_ff <= nxt_run_control_bit;
            jsel_ff            <= nxt_jsel;
            perr_ff            <= nxt_perr;
            irq_ff             <= nxt_irq;
            start_ff           <= nxt_start;
            ramsel_ff          <= nxt_ramsel;
            ack_ff             <= nxt_ack;
            dat_ff             <= nxt_dat;
        end
    end

    assign WB_DAT_O                   = dat_ff;
    assign WB_ACK_O                   = ack_ff;
    assign CS_ADDR                    = csa_ff;
    assign SEQ_D                      = seqd_ff;
    assign ALU_Y_OUT                  = y_ff;
    assign ALU_Y_OE_N                 = oe_n_ff;
    assign CONSTANT_FIELD             = cst_ff;
    assign CONTROL_STORE_PARITY_ERROR = pe_ff;
    assign GATED_PHASE                = gated_phase;
    assign PROCESSOR_RUNNING          = running;
endmodule : mwd_top

// >>> verif/mwd_properties.sv
/* Port checks for mwd_top: bus handshake, phase order, decode timing.
   Assumes one clock domain and a bind onto every mwd_top instance. */
`timescale 1ns/1ps
module mwd_properties (
    input wire logic                     REF_CLK,
    input wire logic                     SRST,
    input wire logic                     WB_CYC_I,
    input wire logic                     WB_STB_I,
    input wire logic                     WB_ACK_O,
    input wire logic [mwd_pkg::CSA_W-1:0] CS_ADDR,
    input wire logic [mwd_pkg::CSA_W-1:0] SEQ_D,
    input wire logic                     ALU_Y_OE_N,
    input wire logic [9:0]               CONSTANT_FIELD,
    input wire logic                     CONTROL_STORE_PARITY_ERROR,
    input wire logic [3:0]               GATED_PHASE,
    input wire logic                     PROCESSOR_RUNNING
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    a_ack_answers: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
    a_phase_onehot: assert property ($onehot0(GATED_PHASE)) else $error("phase not one-hot");
    a_phase_order: assert property (GATED_PHASE[2:0] != 3'h0 |=>
        GATED_PHASE == ($past(GATED_PHASE) << 1) || GATED_PHASE == 4'h0) else $error("phase order");
    a_phase_gated: assert property (GATED_PHASE != 4'h0 |-> PROCESSOR_RUNNING || $past(PROCESSOR_RUNNING))
        else $error("phase while idle");
    a_const_phase: assert property ($changed(CONSTANT_FIELD) |-> GATED_PHASE[1] || $past(GATED_PHASE[1]))
        else $error("constant off phase");
    a_jump_phase: assert property ($changed(SEQ_D) |-> GATED_PHASE[1] || $past(GATED_PHASE[1]))
        else $error("jump off phase");
    a_perr_halts: assert property ($rose(CONTROL_STORE_PARITY_ERROR) |-> ##[0:4] !PROCESSOR_RUNNING)
        else $error("no halt");
    a_oe_clean: assert property (!ALU_Y_OE_N |-> !CONTROL_STORE_PARITY_ERROR && PROCESSOR_RUNNING)
        else $error("drive on error");
    a_oe_brief: assert property ($fell(ALU_Y_OE_N) |-> GATED_PHASE[3] ##1 ALU_Y_OE_N)
        else $error("drive window");
    a_addr_hold: assert property (PROCESSOR_RUNNING && $changed(CS_ADDR) |-> $past(GATED_PHASE[3]))
        else $error("address moved");
    c_full_cycle: cover property (GATED_PHASE == 4'h8);
    c_perr: cover property ($rose(CONTROL_STORE_PARITY_ERROR));
    c_bus_drive: cover property (!ALU_Y_OE_N);
endmodule : mwd_properties
bind mwd_top mwd_properties u_props (.REF_CLK(REF_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CS_ADDR(CS_ADDR), .SEQ_D(SEQ_D), .ALU_Y_OE_N(ALU_Y_OE_N),
    .CONSTANT_FIELD(CONSTANT_FIELD), .CONTROL_STORE_PARITY_ERROR(CONTROL_STORE_PARITY_ERROR),
    .GATED_PHASE(GATED_PHASE), .PROCESSOR_RUNNING(PROCESSOR_RUNNING));

// >>> verif/mwd_cs_model.sv
/* Control store and next-address source for the microword bench.
   Assumes an asynchronous read of the word at cs_addr. */
`timescale 1ns/1ps
module mwd_cs_model (
    input  wire logic [11:0] cs_addr,
    input  wire logic        bad_parity,
    output logic [59:0]      cs_data,
    output logic [11:0]      next_addr
);
    always_comb begin
        cs_data = {~cs_addr, 2'b01, 10'h2AB, 3'h7, cs_addr[2:0], 3'h1, 27'h0};
        cs_data[47] = ~(^cs_data[59:1]) ^ bad_parity;
        next_addr = cs_addr + 12'h001;
    end
endmodule : mwd_cs_model

// >>> verif/tb_microword_register_alu_decode.sv
/* Bench for mwd_top: Wishbone accesses, microcycle decode checks, parity halt.
   Assumes the checker binds itself and the store model answers at once. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_microword_register_alu_decode;
    logic        ref_clk, srst, cyc, stb, we, bad, ack, oe_n, perr, run;
    logic [7:0]  adr;
    logic [31:0] wdat, rd, dato;
    logic [59:0] cs_data;
    logic [11:0] cs_addr, next_addr, seq_d, a;
    logic [35:0] ibus, y, d_op;
    logic [9:0]  cfield;
    logic [3:0]  phase;
    int          miscompares, n_compared, k;
    mwd_top u_dut (.REF_CLK(ref_clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack),
        .CS_DATA(cs_data), .CS_ADDR(cs_addr), .NEXT_ADDR(next_addr), .SEQ_D(seq_d), .IBUS_IN(ibus),
        .ALU_Y_OUT(y), .ALU_Y_OE_N(oe_n), .CONSTANT_FIELD(cfield),
        .CONTROL_STORE_PARITY_ERROR(perr), .GATED_PHASE(phase), .PROCESSOR_RUNNING(run));
    mwd_cs_model u_cs (.cs_addr(cs_addr), .bad_parity(bad), .cs_data(cs_data), .next_addr(next_addr));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, ad, d};
        do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) miscompares++;
        rd = dato;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    // Source D,zero leaves only the function under test in Y
    function automatic logic [35:0] exp_y(input logic [2:0] f);
        case (f)
            3'h0, 3'h2, 3'h3, 3'h6: exp_y = d_op;
            3'h1: exp_y = -d_op;
            3'h7: exp_y = ~d_op;
            default: exp_y = 36'h0;
        endcase
    endfunction : exp_y
    task automatic micro(input logic jsel);
        for (k = 0; k < 40 && phase !== 4'h4; k++) @(posedge ref_clk);
        a = cs_addr;
        `CHK(seq_d, {~a[11:8], jsel ? ibus[19:12] : ~a[7:0]})
        `CHK(cfield, 10'h2AB)
        @(posedge ref_clk);
        `CHK(phase, 4'h8)
        `CHK(oe_n, 1'b0)
        `CHK(y, exp_y(a[2:0]))
        `CHK(cs_addr, a)
    endtask : micro
    initial begin
        #(25 * 6000);
        miscompares++;
        test_done;
    end
    initial begin
        srst = 1'b1;
        {cyc, stb, we, bad, adr, wdat} = '0;
        ibus = 36'h987654321;
        d_op = {10'h2AB, ibus[25:10], 10'h2AB};
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        wb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'b0, 8'h44, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'b1, 8'h08, 32'h4);
        wb(1'b1, 8'h00, 32'h1);
        repeat (4) micro(1'b0);
        `CHK(a, 12'h007)
        $display("test run_plain done");
        wb(1'b1, 8'h00, 32'h3);
        repeat (8) @(posedge ref_clk);
        repeat (8) micro(1'b1);
        $display("test jump_bus done");
        bad <= 1'b1;
        for (k = 0; k < 40 && perr !== 1'b1; k++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        `CHK(run, 1'b0)
        `CHK(oe_n, 1'b1)
        wb(1'b0, 8'h04, 32'h0);
        `CHK(rd[2:0], 3'h3)
        wb(1'b0, 8'h00, 32'h0);
        `CHK(rd[1:0], 2'h2)
        bad <= 1'b0;
        wb(1'b1, 8'h04, 32'h3);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(rd[2:0], 3'h0)
        $display("test parity_halt done");
        test_done;
    end
endmodule : tb_microword_register_alu_decode
